// >>> design/udpw_core.sv
// DMA request, auto-baud completion and sleep/idle auto-wake logic of a serial port.
// Function
// - Baud measurement keeps the receiver idle and stores no received character.
// - Fifth rising edge of measurement sets receive flag, ignoring selection bits.
// - The measurement character leaves the receive queue untouched.
// - Receive DMA request raised for each character ready in receive data.
// - Receive word: byte low, parity and framing status in high byte.
// - With receive DMA on, status read hides framing and parity flags.
// - Error flag set when last reception had framing or parity error.
// - Transmit DMA request after each completed transmitted character.
// - Transmit DMA request fires as soon as module and transmitter enable.
// - Sleep stops the module, aborts transfers, pins return to idle levels.
// - Wake bit and falling receive edge set the receive flag and wake.
// - First character after wake from sleep is not recognised.
// - Wake bit self-clears on the rising line edge after the wake event.
// - Idle keeps running unless stop-in-idle is set, then acts as sleep.
// - While wake bit is set normal reception is off; wake sets receive flag.
// - Wake event is a falling receive edge, watched in every power state.
// - Wake flag is formed on the free clock whether module runs or not.
// - Fifth rising edge loads the measured count and clears measure enable.
// - Measurement expects 55h and spans low and high bit times.
// - Wake receive flag ignores the receive selection field.
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module udpw_core (
   // APB slave port on the free-running peripheral clock.
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [7:0]             paddr,
   input  wire logic [31:0]            pwdata,
   output logic [31:0]                 prdata,
   output logic                        pready,
   output logic                        pslverr,
   // Power state from the system.
   input  wire logic                   sleep_req,
   input  wire logic                   idle_req,
   output logic                        module_clk_en,
   output logic                        wake_out,
   // Receive and transmit core of the port.
   input  wire logic                   rx_char_valid,
   input  wire udpw_pkg::udpw_rx_char_t rx_char,
   output logic                        rx_hold,
   input  wire logic                   tx_char_done,
   output logic [7:0]                  tx_word,
   output logic                        tx_load,
   input  wire logic                   loop_tx_line,
   input  wire udpw_pkg::udpw_pins_t   core_pins,
   // DMA requests and interrupt flags.
   output logic                        rx_dma_req,
   output logic                        tx_dma_req,
   output logic                        rx_irq_flag,
   output logic                        error_irq_flag,
   // Serial pins.
   input  wire logic                   serial_in_pin,
   output logic                        serial_out_pin,
   output logic                        request_to_send_pin,
   output logic                        baud_clock_out_pin
);
   import udpw_pkg::*;

   udpw_state_t       s;
   udpw_state_t       n;
   logic              run;
   logic              stopped;
   logic              rx_line;
   logic              fall;
   logic              rise;
   logic              wr_en;
   logic              rd_setup;
   logic              rd_done;
   logic              mapped;
   logic              rx_take;
   logic              tx_on;
   logic [BRG_W-1:0]  meas_result;
   logic [31:0]       rd_val;

   ////////////////////////////////////////////////////////////////////////////
   // Decodes.

   assign stopped  = sleep_req | (idle_req & s.stop_idle);
   assign run      = s.module_on & ~stopped;
   // Wake watches the pin itself so loopback cannot fake a wake event.
   assign rx_line  = (s.loopback & ~s.wake) ? loop_tx_line : s.rx_s2;
   assign fall     = s.rx_prev & ~rx_line;
   assign rise     = ~s.rx_prev & rx_line;
   assign wr_en    = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign rd_done  = psel & penable & ~pwrite;
   assign mapped   = (paddr == OFS_MODE) | (paddr == OFS_STA) | (paddr == OFS_RXD) |
                     (paddr == OFS_TXD) | (paddr == OFS_BRG) | (paddr == OFS_CTRL) |
                     (paddr == OFS_FLAG);
   assign rx_take  = rx_char_valid & run & ~s.baud_meas & ~s.wake;
   assign tx_on    = run & s.tx_en;
   assign meas_result = s.meas_cnt[MEAS_SHIFT +: BRG_W];

   always_comb begin
      rd_val = 32'h0000_0000;
      unique case (paddr)
         OFS_MODE: begin
            rd_val[MODE_ON_BIT]   = s.module_on;
            rd_val[MODE_SIDL_BIT] = s.stop_idle;
            rd_val[MODE_WAKE_BIT] = s.wake;
            rd_val[MODE_LPBK_BIT] = s.loopback;
            rd_val[MODE_ABD_BIT]  = s.baud_meas;
         end
         OFS_STA: begin
            rd_val[STA_TXSEL_HI_BIT]              = s.tx_sel_hi;
            rd_val[STA_TXSEL_LO_BIT]              = s.tx_sel_lo;
            rd_val[STA_TXEN_BIT]                  = s.tx_en;
            rd_val[STA_RXSEL_LSB +: 2]            = s.rx_sel;
            rd_val[STA_PARITY_ERROR_FLAG_BIT] = s.rx_word.parity_error_flag & ~s.rx_dma_en;
            rd_val[STA_FRAMING_ERROR_FLAG_BIT] = s.rx_word.framing_error_flag & ~s.rx_dma_en;
            rd_val[STA_RXAV_BIT]                  = s.rx_avail;
         end
         OFS_RXD: begin
            rd_val[7:0]           = s.rx_word.data;
            rd_val[WORD_PARITY_ERROR_FLAG_BIT] = s.rx_word.parity_error_flag;
            rd_val[WORD_FRAMING_ERROR_FLAG_BIT] = s.rx_word.framing_error_flag;
         end
         OFS_TXD:  rd_val[7:0] = s.tx_word;
         OFS_BRG:  rd_val[BRG_W-1:0] = s.brg;
         OFS_CTRL: begin
            rd_val[CTRL_RXDMA_BIT] = s.rx_dma_en;
            rd_val[CTRL_TXDMA_BIT] = s.tx_dma_en;
            rd_val[CTRL_RXIE_BIT]  = s.rx_ie;
            rd_val[CTRL_EIE_BIT]   = s.err_ie;
         end
         OFS_FLAG: begin
            rd_val[FLAG_RXIF_BIT] = s.rx_flag;
            rd_val[FLAG_EIF_BIT]  = s.err_flag;
         end
         default: rd_val = 32'h0000_0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state.

   always_comb begin
      n = s;
      // The first stage feeds only the second stage.
      n.rx_s1      = serial_in_pin;
      n.rx_s2      = s.rx_s1;
      n.rx_prev    = rx_line;
      n.rx_dma_req = 1'b0;
      n.tx_dma_req = 1'b0;
      n.tx_load    = 1'b0;
      if (rd_setup) begin
         n.prdata = rd_val;
      end

      // Software writes; hardware updates below take priority.
      if (wr_en) begin
         unique case (paddr)
            OFS_MODE: begin
               n.module_on = pwdata[MODE_ON_BIT];
               n.stop_idle = pwdata[MODE_SIDL_BIT];
               n.wake      = pwdata[MODE_WAKE_BIT];
               n.loopback  = pwdata[MODE_LPBK_BIT];
               n.baud_meas = pwdata[MODE_ABD_BIT];
            end
            OFS_STA: begin
               n.tx_sel_hi = pwdata[STA_TXSEL_HI_BIT];
               n.tx_sel_lo = pwdata[STA_TXSEL_LO_BIT];
               n.tx_en     = pwdata[STA_TXEN_BIT];
               n.rx_sel    = pwdata[STA_RXSEL_LSB +: 2];
            end
            OFS_TXD: begin
               n.tx_word = pwdata[7:0];
               n.tx_load = 1'b1;
            end
            OFS_BRG:  n.brg = pwdata[BRG_W-1:0];
            OFS_CTRL: begin
               n.rx_dma_en = pwdata[CTRL_RXDMA_BIT];
               n.tx_dma_en = pwdata[CTRL_TXDMA_BIT];
               n.rx_ie     = pwdata[CTRL_RXIE_BIT];
               n.err_ie    = pwdata[CTRL_EIE_BIT];
            end
            OFS_FLAG: begin
               if (pwdata[FLAG_RXIF_BIT]) n.rx_flag = 1'b0;
               if (pwdata[FLAG_EIF_BIT])  n.err_flag = 1'b0;
            end
            default: n.brg = s.brg;
         endcase
      end
      if (rd_done && paddr == OFS_RXD) begin
         n.rx_avail = 1'b0;
      end

      // Baud measurement; a stop aborts it and it restarts on resume.
      if (!s.baud_meas || !run) begin
         n.meas = MEAS_OFF;
      end else begin
         unique case (s.meas)
            MEAS_OFF: begin
               n.meas     = MEAS_START;
               n.meas_cnt = '0;
            end
            MEAS_START: if (fall) n.meas = MEAS_EDGE1;
            MEAS_EDGE1: if (rise) begin
               n.meas     = MEAS_RUN;
               n.edge_cnt = 3'h1;
            end
            MEAS_RUN: begin
               n.meas_cnt = s.meas_cnt + 1'b1;
               if (rise) begin
                  n.edge_cnt = s.edge_cnt + 3'h1;
                  if (s.edge_cnt == MEAS_EDGES - 3'h1) begin
                     n.brg       = meas_result;
                     n.baud_meas = 1'b0;
                     n.meas      = MEAS_OFF;
                     n.rx_flag   = 1'b1;
                  end
               end
            end
         endcase
      end

      // Received characters; the measurement character never arrives here.
      if (rx_take) begin
         if (s.skip_first) begin
            n.skip_first = 1'b0;
         end else begin
            n.rx_word  = rx_char;
            n.rx_avail = 1'b1;
            // Single-entry queue, so every selection value flags each character.
            n.rx_flag  = 1'b1;
            n.rx_dma_req = s.rx_dma_en;
            if (rx_char.framing_error_flag || rx_char.parity_error_flag) begin
               n.err_flag = 1'b1;
            end
         end
      end

      // Auto-wake runs on the free clock, module clocks or not.
      if (!s.wake) begin
         n.wake_seen = 1'b0;
      end else if (!s.wake_seen && fall) begin
         n.wake_seen = 1'b1;
         n.rx_flag   = 1'b1;
         if (stopped) begin
            n.skip_first = 1'b1;
         end
      end else if (s.wake_seen && rise) begin
         n.wake      = 1'b0;
         n.wake_seen = 1'b0;
      end

      // Transmit requests: one at enable, then one per finished character.
      n.tx_armed = tx_on;
      if (s.tx_dma_en && tx_on && (!s.tx_armed || tx_char_done)) begin
         n.tx_dma_req = 1'b1;
      end

      // Stopped module drives idle pin levels and aborts transfers.
      if (run) begin
         n.pins = core_pins;
      end else begin
         n.pins = '{tx: TX_IDLE, rts: RTS_IDLE, bclk: BCLK_IDLE};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s          <= '0;
         s.rx_s1    <= 1'b1;
         s.rx_s2    <= 1'b1;
         s.rx_prev  <= 1'b1;
         s.brg      <= BRG_RESET;
         s.meas     <= MEAS_OFF;
         s.pins     <= '{tx: TX_IDLE, rts: RTS_IDLE, bclk: BCLK_IDLE};
      end else begin
         s <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign prdata              = s.prdata;
   assign pready              = 1'b1;
   assign pslverr             = psel & penable & ~mapped;
   assign module_clk_en       = run;
   assign rx_hold             = ~run | s.baud_meas | s.wake;
   assign wake_out            = s.rx_flag & s.rx_ie;
   assign tx_word             = s.tx_word;
   assign tx_load             = s.tx_load;
   assign rx_dma_req          = s.rx_dma_req;
   assign tx_dma_req          = s.tx_dma_req;
   assign rx_irq_flag         = s.rx_flag;
   assign error_irq_flag      = s.err_flag & s.err_ie;
   assign serial_out_pin      = s.pins.tx;
   assign request_to_send_pin = s.pins.rts;
   assign baud_clock_out_pin  = s.pins.bclk;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence wake_event_s;
      s.wake && !s.wake_seen && fall;
   endsequence

   sequence wake_end_s;
      s.wake_seen && s.wake && rise;
   endsequence

   chk_meas_no_store: assert property (
      s.baud_meas && rx_char_valid |=> $stable(s.rx_word) && !s.rx_dma_req)
      else $error("character stored during baud measurement");

   chk_meas_fifth_edge: assert property (
      run && s.baud_meas && s.meas == MEAS_RUN && s.edge_cnt == 3'h4 && rise
      |=> s.rx_flag && !s.baud_meas && s.brg == $past(meas_result))
      else $error("baud measurement end not handled on fifth edge");

   chk_rx_dma_pulse: assert property (
      rx_take && !s.skip_first && s.rx_dma_en |=> rx_dma_req ##1 !rx_dma_req)
      else $error("receive DMA request not a single pulse");

   chk_rx_word_fmt: assert property (
      rd_setup && paddr == OFS_RXD |=> prdata[7:0] == $past(s.rx_word.data)
      && prdata[WORD_PARITY_ERROR_FLAG_BIT] == $past(s.rx_word.parity_error_flag)
      && prdata[WORD_FRAMING_ERROR_FLAG_BIT] == $past(s.rx_word.framing_error_flag))
      else $error("receive word layout wrong");

   chk_status_hide: assert property (
      rd_setup && paddr == OFS_STA && s.rx_dma_en
      |=> !prdata[STA_PARITY_ERROR_FLAG_BIT] && !prdata[STA_FRAMING_ERROR_FLAG_BIT])
      else $error("error bits visible in status under DMA");

   chk_err_flag: assert property (
      rx_take && !s.skip_first && (rx_char.framing_error_flag || rx_char.parity_error_flag) |=> s.err_flag)
      else $error("error flag not set after bad character");

   chk_tx_dma_req: assert property (
      s.tx_dma_en && tx_on && (!s.tx_armed || tx_char_done) |=> tx_dma_req ##1 !tx_dma_req)
      else $error("transmit DMA request missing");

   chk_stop_pins: assert property (
      !run |=> serial_out_pin == TX_IDLE && request_to_send_pin == RTS_IDLE
      && baud_clock_out_pin == BCLK_IDLE)
      else $error("pins not at idle level while stopped");

   chk_wake_flag: assert property (
      wake_event_s |=> s.rx_flag && s.wake_seen && s.wake)
      else $error("wake event did not raise receive flag");

   chk_wake_clear: assert property (
      wake_end_s |=> !s.wake && !s.wake_seen)
      else $error("wake bit not cleared after rising edge");

   chk_wake_skip: assert property (
      s.skip_first && rx_take |=> !rx_dma_req && $stable(s.rx_word) && !s.skip_first)
      else $error("first character after wake was taken");

endmodule

`default_nettype wire

// >>> design/udpw_pkg.sv
// Shared constants, register map and carrier types for the serial DMA and wake logic.
package udpw_pkg;

   // Register byte offsets on the APB port.
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_STA  = 8'h04;
   localparam logic [7:0] OFS_RXD  = 8'h08;
   localparam logic [7:0] OFS_TXD  = 8'h0C;
   localparam logic [7:0] OFS_BRG  = 8'h10;
   localparam logic [7:0] OFS_CTRL = 8'h14;
   localparam logic [7:0] OFS_FLAG = 8'h18;

   // mode_reg fields.
   localparam int MODE_ON_BIT   = 15;
   localparam int MODE_SIDL_BIT = 13;
   localparam int MODE_WAKE_BIT = 7;
   localparam int MODE_LPBK_BIT = 6;
   localparam int MODE_ABD_BIT  = 5;

   // status_control_reg fields.
   localparam int STA_TXSEL_HI_BIT = 15;
   localparam int STA_TXSEL_LO_BIT = 13;
   localparam int STA_TXEN_BIT     = 10;
   localparam int STA_RXSEL_LSB    = 6;
   localparam int STA_PARITY_ERROR_FLAG_BIT     = 3;
   localparam int STA_FRAMING_ERROR_FLAG_BIT     = 2;
   localparam int STA_RXAV_BIT     = 0;

   // Control and flag registers.
   localparam int CTRL_RXDMA_BIT = 0;
   localparam int CTRL_TXDMA_BIT = 1;
   localparam int CTRL_RXIE_BIT  = 2;
   localparam int CTRL_EIE_BIT   = 3;
   localparam int FLAG_RXIF_BIT  = 0;
   localparam int FLAG_EIF_BIT   = 1;

   // Status positions in the 16-bit receive word.
   localparam int WORD_PARITY_ERROR_FLAG_BIT = 11;
   localparam int WORD_FRAMING_ERROR_FLAG_BIT = 10;

   // Baud measurement: rising edges to the end, and the count scaling
   // (eight bit times of sixteen baud clocks each).
   localparam int         BRG_W       = 16;
   localparam int         MEAS_SHIFT  = 7;
   localparam int         MEAS_W      = BRG_W + MEAS_SHIFT;
   localparam logic [2:0] MEAS_EDGES  = 3'h5;

   // Reset values and idle pin levels.
   localparam logic [15:0] BRG_RESET  = 16'h0000;
   localparam logic        TX_IDLE    = 1'b1;
   localparam logic        RTS_IDLE   = 1'b1;
   localparam logic        BCLK_IDLE  = 1'b0;

   typedef struct packed {
      logic       parity_error_flag;
      logic       framing_error_flag;
      logic [7:0] data;
   } udpw_rx_char_t;

   typedef struct packed {
      logic tx;
      logic rts;
      logic bclk;
   } udpw_pins_t;

   typedef enum logic [1:0] {MEAS_OFF, MEAS_START, MEAS_EDGE1, MEAS_RUN} udpw_meas_t;

   typedef struct packed {
      logic              rx_s1;
      logic              rx_s2;
      logic              rx_prev;
      logic              module_on;
      logic              stop_idle;
      logic              wake;
      logic              loopback;
      logic              baud_meas;
      logic              tx_sel_hi;
      logic              tx_sel_lo;
      logic              tx_en;
      logic [1:0]        rx_sel;
      logic [BRG_W-1:0]  brg;
      logic              rx_dma_en;
      logic              tx_dma_en;
      logic              rx_ie;
      logic              err_ie;
      logic              rx_flag;
      logic              err_flag;
      udpw_rx_char_t     rx_word;
      logic              rx_avail;
      udpw_meas_t        meas;
      logic [2:0]        edge_cnt;
      logic [MEAS_W-1:0] meas_cnt;
      logic              wake_seen;
      logic              skip_first;
      logic              tx_armed;
      logic              rx_dma_req;
      logic              tx_dma_req;
      logic [7:0]        tx_word;
      logic              tx_load;
      udpw_pins_t        pins;
      logic [31:0]       prdata;
   } udpw_state_t;

endpackage

// >>> testbench/udpw_dma_model.sv
// Behavioural DMA controller and CPU wake logic facing the serial port.
`timescale 1ns/100ps
`default_nettype none
module udpw_dma_model (
   // Clock and reset.
   input  wire logic pclk,
   input  wire logic presetn,
   // Requests from the port.
   input  wire logic rx_dma_req,
   input  wire logic tx_dma_req,
   input  wire logic wake_out,
   // Tallies read by the bench.
   output int        rx_cnt,
   output int        tx_cnt,
   output int        dbl_cnt,
   output logic      cpu_woken
);
   logic rx_q;
   logic tx_q;
   // A request held for two cycles would move two words, so it is tallied as a fault.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_cnt <= 0;
         tx_cnt <= 0;
         dbl_cnt <= 0;
         rx_q <= 1'b0;
         tx_q <= 1'b0;
         cpu_woken <= 1'b0;
      end else begin
         rx_cnt <= rx_cnt + int'(rx_dma_req);
         tx_cnt <= tx_cnt + int'(tx_dma_req);
         dbl_cnt <= dbl_cnt + int'(rx_dma_req && rx_q) + int'(tx_dma_req && tx_q);
         rx_q <= rx_dma_req;
         tx_q <= tx_dma_req;
         // A level rather than a sticky bit, so every wake is seen afresh.
         cpu_woken <= (wake_out === 1'b1);
      end
   end
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench for the serial DMA, auto-baud and wake logic.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import udpw_pkg::*;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] r; logic e;} udpw_row_t;
   logic          pclk, presetn, psel, penable, pwrite, sleep_req, idle_req, err;
   logic          rx_char_valid, tx_char_done, serial_in_pin, pready, pslverr, tx_load;
   logic          module_clk_en, wake_out, rx_hold, rx_dma_req, tx_dma_req, cpu_woken;
   logic          rx_irq_flag, error_irq_flag, serial_out_pin;
   logic          request_to_send_pin, baud_clock_out_pin;
   logic [7:0]    paddr, tx_word;
   logic [31:0]   pwdata, prdata, rd;
   udpw_rx_char_t rx_char;
   udpw_pins_t    core_pins;
   int            n_fail, tests_run, rx_cnt, tx_cnt, dbl_cnt, i;
   udpw_row_t     rows [5];

   always #12.5 pclk = ~pclk;

   udpw_core uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .sleep_req, .idle_req, .module_clk_en, .wake_out, .rx_char_valid,
      .rx_char, .rx_hold, .tx_char_done, .tx_word, .tx_load, .loop_tx_line(serial_out_pin),
      .core_pins, .rx_dma_req, .tx_dma_req, .rx_irq_flag, .error_irq_flag, .serial_in_pin,
      .serial_out_pin, .request_to_send_pin, .baud_clock_out_pin);
   udpw_dma_model dma (.pclk, .presetn, .rx_dma_req, .tx_dma_req, .wake_out, .rx_cnt,
      .tx_cnt, .dbl_cnt, .cpu_woken);

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic ticks(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // Waits are bounded so a slave that never answers ends the run instead of hanging.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      err = pslverr;
      if (k == 50) begin
         n_fail++;
         wrap_up();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rxc(input logic p, input logic f, input logic [7:0] b);
      @(posedge pclk);
      rx_char_valid <= 1'b1;
      rx_char <= '{parity_error_flag: p, framing_error_flag: f, data: b};
      @(posedge pclk);
      rx_char_valid <= 1'b0;
   endtask

   initial begin
      ticks(100000);
      n_fail++;
      wrap_up();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {pclk, presetn, psel, penable, pwrite, sleep_req, idle_req} = '0;
      {rx_char_valid, tx_char_done, paddr, pwdata, rx_char} = '0;
      serial_in_pin = 1'b1;
      core_pins = '{tx: 1'b0, rts: 1'b0, bclk: 1'b1};
      n_fail = 0;
      tests_run = 0;
      rows[0] = '{OFS_MODE, 32'h0000_2040, 32'h0000_2040, 1'b0};
      rows[1] = '{OFS_STA, 32'h0000_A4C0, 32'h0000_A4C0, 1'b0};
      rows[2] = '{OFS_BRG, 32'h0000_1234, 32'h0000_1234, 1'b0};
      rows[3] = '{OFS_CTRL, 32'h0000_000F, 32'h0000_000F, 1'b0};
      rows[4] = '{8'h1C, 32'h0000_FFFF, 32'h0000_0000, 1'b1};
      ticks(20);
      chk({module_clk_en, rx_hold, serial_out_pin, request_to_send_pin}, 4'h7);
      presetn <= 1'b1;
      for (i = 0; i < 5; i++) begin
         apb(1'b1, rows[i].a, rows[i].d);
         apb(1'b0, rows[i].a, 32'h0000_0000);
         chk(rd, rows[i].r);
         chk(err, rows[i].e);
      end
      $display("test registers finished");
      apb(1'b1, OFS_STA, 32'h0000_0040);
      apb(1'b1, OFS_CTRL, 32'h0000_000D);
      apb(1'b1, OFS_MODE, 32'h0000_8000);
      rxc(1'b1, 1'b0, 8'hA5);
      ticks(2);
      chk(rx_cnt, 1);
      chk({rx_hold, serial_out_pin, request_to_send_pin, baud_clock_out_pin}, 4'h1);
      chk(error_irq_flag, 1'b1);
      apb(1'b0, OFS_STA, 32'h0000_0000);
      chk(rd, 32'h0000_0041);
      apb(1'b0, OFS_RXD, 32'h0000_0000);
      chk(rd, 32'h0000_08A5);
      rxc(1'b0, 1'b0, 8'h3C);
      rxc(1'b0, 1'b1, 8'hC3);
      ticks(2);
      chk(rx_cnt, 3);
      apb(1'b0, OFS_RXD, 32'h0000_0000);
      $display("test receive dma finished");
      apb(1'b1, OFS_STA, 32'h0000_00C0);
      apb(1'b1, OFS_FLAG, 32'h0000_0003);
      apb(1'b1, OFS_MODE, 32'h0000_8020);
      // Start bit, 55h and stop bit at 72 clocks a bit: 576 clocks over eight bits.
      fork
         for (i = 0; i < 10; i++) begin
            serial_in_pin <= 1'(10'h2AA >> i);
            ticks(72);
         end
         begin
            ticks(300);
            rxc(1'b0, 1'b0, 8'h77);
         end
      join
      chk(rx_cnt, 3);
      apb(1'b0, OFS_BRG, 32'h0000_0000);
      chk(rd, 32'h0000_0004);
      apb(1'b0, OFS_MODE, 32'h0000_0000);
      chk(rd, 32'h0000_8000);
      apb(1'b0, OFS_FLAG, 32'h0000_0000);
      chk(rd[0], 1'b1);
      apb(1'b0, OFS_STA, 32'h0000_0000);
      chk(rd, 32'h0000_00C0);
      $display("test baud measurement finished");
      apb(1'b1, OFS_CTRL, 32'h0000_000F);
      apb(1'b1, OFS_STA, 32'h0000_04C0);
      ticks(3);
      chk(tx_cnt, 1);
      tx_char_done <= 1'b1;
      ticks(1);
      tx_char_done <= 1'b0;
      ticks(2);
      chk(tx_cnt, 2);
      apb(1'b1, OFS_TXD, 32'h0000_005A);
      ticks(1);
      chk(tx_load, 1'b1);
      ticks(1);
      chk({tx_load, tx_word}, 9'h05A);
      $display("test transmit dma finished");
      apb(1'b1, OFS_FLAG, 32'h0000_0003);
      apb(1'b1, OFS_MODE, 32'h0000_8080);
      rxc(1'b0, 1'b0, 8'h11);
      ticks(2);
      chk(rx_cnt, 3);
      chk(rx_hold, 1'b1);
      sleep_req <= 1'b1;
      ticks(3);
      chk({module_clk_en, serial_out_pin, request_to_send_pin, baud_clock_out_pin}, 4'h6);
      chk(cpu_woken, 1'b0);
      serial_in_pin <= 1'b0;
      for (i = 0; i < 20 && rx_irq_flag !== 1'b1; i++) ticks(1);
      if (i == 20) begin
         n_fail++;
         wrap_up();
      end
      chk(rx_irq_flag, 1'b1);
      ticks(2);
      chk(cpu_woken, 1'b1);
      sleep_req <= 1'b0;
      ticks(10);
      serial_in_pin <= 1'b1;
      ticks(6);
      apb(1'b0, OFS_MODE, 32'h0000_0000);
      chk(rd, 32'h0000_8000);
      rxc(1'b0, 1'b0, 8'h22);
      ticks(2);
      chk(rx_cnt, 3);
      rxc(1'b0, 1'b0, 8'h33);
      ticks(2);
      chk(rx_cnt, 4);
      $display("test sleep and wake finished");
      idle_req <= 1'b1;
      ticks(2);
      chk(module_clk_en, 1'b1);
      apb(1'b1, OFS_MODE, 32'h0000_A000);
      ticks(2);
      chk({module_clk_en, serial_out_pin, request_to_send_pin, baud_clock_out_pin}, 4'h6);
      chk(dbl_cnt, 0);
      $display("test idle finished");
      wrap_up();
   end
endmodule
`default_nettype wire
